/* dv/tb.sv */
// Self-checking bench for the bit, shift and stack execution unit
`timescale 1ns/10ps
module tb;
	import bit_ops_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cmd_valid = 1'b0;
	cmd_t cmd = '0;
	logic cmd_ready;
	logic done;
	logic [7:0] bus_addr = 8'h00;
	logic [7:0] bus_wdata = 8'h00;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [7:0] bus_rdata;
	logic rd_q = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] wr_m[32];
	logic [7:0] io_m[32];
	logic [7:0] stk_m[16];
	logic [7:0] fl_m;
	logic [3:0] sp_m;
	logic [31:0] seed = 32'h0000_0021;
	int n_mismatch = 0;
	int compares = 0;
	int cycles = 0;

	bit_ops_unit dut
	(
		.clk(clk),
		.rstn(rstn),
		.cmd_valid(cmd_valid),
		.cmd(cmd),
		.cmd_ready(cmd_ready),
		.done(done),
		.bus_addr(bus_addr),
		.bus_wdata(bus_wdata),
		.bus_wr(bus_wr),
		.bus_rd(bus_rd),
		.bus_rdata(bus_rdata)
	);

	// 20 MHz clock
	always #25 clk = ~clk;

	// ****************************************
	// Helpers
	// ****************************************
	// Xorshift keeps the run repeatable
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("Compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Gap cycle after each strobe so no signal is assigned twice in one step
	task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		@(posedge clk);
	endtask

	// Read data stands only in the cycle after the strobe
	always @(posedge clk)
	begin
		rd_q <= bus_rd;
		if (rd_q)
			chk(bus_rdata, exp_q.pop_front());
	end

	// Hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_mismatch++;
			$display("Error at %0t: run timed out", $time);
			complete_run();
		end
	end

	// ****************************************
	// Command driver and model
	// ****************************************
	task automatic step(input op_t op);
		logic [4:0] r;
		logic [4:0] io;
		logic [2:0] b;
		logic [7:0] v;
		logic c;
		int n;
		r = 5'(xs());
		io = 5'(xs());
		b = 3'(xs());
		wr_m[r] = 8'(xs());
		io_m[io] = 8'(xs());
		fl_m = 8'(xs());
		bus_write(WREG_BASE + 8'(r), wr_m[r]);
		bus_write(IO_BASE + 8'(io), io_m[io]);
		bus_write(FLAGS_ADDR, fl_m);
		v = wr_m[r];
		c = fl_m[FLAG_C];
		case (op)
			OP_PUSH:
			begin
				stk_m[sp_m] = v;
				sp_m--;
			end
			OP_POP:
			begin
				sp_m++;
				v = stk_m[sp_m];
			end
			OP_IO_SET: io_m[io][b] = 1'b1;
			OP_IO_CLR: io_m[io][b] = 1'b0;
			OP_LSL: {c, v} = {v, 1'b0};
			OP_LSR: {v, c} = {1'b0, v};
			OP_ROL: {c, v} = {v, c};
			OP_ROR: {v, c} = {c, v};
			OP_ASR: {v, c} = {v[7], v};
			OP_SWAP: v = {v[3:0], v[7:4]};
			OP_FSET: fl_m[b] = 1'b1;
			OP_FCLR: fl_m[b] = 1'b0;
			default: ;
		endcase
		// Only shifts and rotates compute the arithmetic flags from the result; flag set/clear may force one of them
		if (op inside {[OP_LSL:OP_ASR]})
		begin
			fl_m[FLAG_C] = c;
			fl_m[FLAG_Z] = (v == 8'h00);
			fl_m[FLAG_N] = v[7];
			fl_m[FLAG_V] = v[7] ^ c;
		end
		wr_m[r] = v;
		n = 0;
		cmd_valid <= 1'b1;
		cmd <= '{op: op, reg_sel: r, io_sel: io, bit_sel: b};
		@(posedge clk);
		cmd_valid <= 1'b0;
		// Ready must drop for the extra cycle of a stack op and be back with done
		do
		begin
			@(posedge clk);
			n++;
			if (n == 1)
				chk(8'(cmd_ready), (op == OP_PUSH || op == OP_POP) ? 8'h00 : 8'h01);
		end while (done !== 1'b1 && n < 6);
		chk(8'(cmd_ready), 8'h01);
		chk(8'(n), (op == OP_PUSH || op == OP_POP) ? 8'h02 : 8'h01);
		rd_chk(WREG_BASE + 8'(r), wr_m[r]);
		rd_chk(IO_BASE + 8'(io), io_m[io]);
		rd_chk(FLAGS_ADDR, fl_m);
		rd_chk(SP_ADDR, {4'h0, sp_m});
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		wr_m = '{default: 8'h00};
		io_m = '{default: 8'h00};
		stk_m = '{default: 8'h00};
		fl_m = FLAGS_RST;
		sp_m = SP_RST;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd_chk(FLAGS_ADDR, FLAGS_RST);
		rd_chk(SP_ADDR, {4'h0, SP_RST});
		$display("Reset test done");
		// Every op twice in order, then a random mix
		for (int i = 0; i < 60; i++)
			step(op_t'(4'(i < 24 ? i % 12 : xs() % 12)));
		$display("Op test done");
		bus_write(8'h80, 8'h5a);
		rd_chk(8'h80, 8'h00);
		$display("Unmapped test done");
		repeat (2) @(posedge clk);
		complete_run();
	end
endmodule

/* logic/bit_ops_pkg.sv */
// Package: shared types and constants for the bit, shift and stack unit
package bit_ops_pkg;

	// ********************************************************
	// Operation codes and command carrier
	// ********************************************************
	typedef enum logic [3:0]
	{
		OP_PUSH,
		OP_POP,
		OP_IO_SET,
		OP_IO_CLR,
		OP_LSL,
		OP_LSR,
		OP_ROL,
		OP_ROR,
		OP_ASR,
		OP_SWAP,
		OP_FSET,
		OP_FCLR
	} op_t;

	typedef struct packed
	{
		op_t op;
		logic [4:0] reg_sel; // Working register, destination or source
		logic [4:0] io_sel; // I/O register index
		logic [2:0] bit_sel; // Bit within I/O register or flag register
	} cmd_t;

	// ********************************************************
	// Register bus map
	// ********************************************************
	typedef enum logic [2:0]
	{
		AREA_WREG,
		AREA_IO,
		AREA_FLAGS,
		AREA_SP,
		AREA_NONE
	} area_t;

	localparam logic [7:0] WREG_BASE = 8'h00;
	localparam logic [7:0] IO_BASE = 8'h20;
	localparam logic [7:0] FLAGS_ADDR = 8'h40;
	localparam logic [7:0] SP_ADDR = 8'h41;

	// ********************************************************
	// Flag positions and reset values
	// ********************************************************
	localparam logic [2:0] FLAG_C = 3'h0;
	localparam logic [2:0] FLAG_Z = 3'h1;
	localparam logic [2:0] FLAG_N = 3'h2;
	localparam logic [2:0] FLAG_V = 3'h3;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [3:0] SP_RST = 4'hf;
	localparam logic [7:0] BYTE_RST = 8'h00;

endpackage

/* logic/bit_ops_unit.sv */
// Module: bit set/clear, shift, rotate, swap, flag and stack execution unit
`timescale 1ns/10ps
// Function
// - Push writes the chosen working register onto the stack, keeps all flags and takes two cycles.
// - Pop loads the chosen working register with the stack byte and keeps all flags.
// - I/O bit set forces the chosen bit of the chosen I/O register high, nothing else changes.
// - I/O bit clear forces the chosen bit of the chosen I/O register low, other bits stay.
// - Logical shift left moves bits up, fills bit 0 with zero and updates Z, C, N and V.
// - Logical shift right moves bits down, fills bit 7 with zero and updates Z, C, N and V.
// - Rotate left puts old carry in bit 0, shifts bits up and moves old bit 7 to carry.
// - Rotate right puts old carry in bit 7, shifts bits down and moves old bit 0 to carry.
// - Arithmetic shift right moves bits down, keeps bit 7 and updates the arithmetic flags.
// - Nibble swap exchanges the two halves of the register and keeps all flags.
// - Flag set forces one chosen flag high in one cycle and touches no other flag.
// - Flag clear forces one chosen flag low and touches no other flag.
module bit_ops_unit
	import bit_ops_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic cmd_valid,
	input wire cmd_t cmd,
	output logic cmd_ready,
	output logic done,
	input wire logic [7:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata
);

	// ********************************************************
	// Decode and datapath helpers
	// ********************************************************

	// Address class, shared by the read and the write path
	function automatic area_t area_of(input logic [7:0] a);
		if (a < IO_BASE)
			return AREA_WREG;
		else if (a < FLAGS_ADDR)
			return AREA_IO;
		else if (a == FLAGS_ADDR)
			return AREA_FLAGS;
		else if (a == SP_ADDR)
			return AREA_SP;
		else
			return AREA_NONE;
	endfunction

	// Shift and rotate result with the carry out in the top bit
	function automatic logic [8:0] shift_calc(input op_t op, input logic [7:0] v, input logic c);
		logic [8:0] r;
		r = {1'b0, v};
		case (op)
			OP_LSL: r = {v[7], v[6:0], 1'b0};
			OP_LSR: r = {v[0], 1'b0, v[7:1]};
			OP_ROL: r = {v[7], v[6:0], c};
			OP_ROR: r = {v[0], c, v[7:1]};
			OP_ASR: r = {v[0], v[7], v[7:1]};
			default: r = {c, v};
		endcase
		return r;
	endfunction

	// ********************************************************
	// State
	// ********************************************************
	typedef enum logic [1:0] {ST_IDLE, ST_PUSH2, ST_POP2} state_t;

	state_t st_r, st_nxt;
	logic [7:0] wreg_r [32];
	logic [7:0] wreg_nxt [32];
	logic [7:0] io_r [32];
	logic [7:0] io_nxt [32];
	logic [7:0] stk_r [16];
	logic [7:0] stk_nxt [16];
	logic [3:0] sp_r, sp_nxt;
	logic [7:0] status_flags_reg_r, status_flags_reg_nxt;
	logic [4:0] hold_r, hold_nxt;
	logic ready_r, ready_nxt;
	logic done_r, done_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic fire;
	logic [7:0] src_val;
	logic [8:0] sh;

	assign fire = cmd_valid && ready_r;
	assign src_val = wreg_r[cmd.reg_sel];
	assign sh = shift_calc(cmd.op, src_val, status_flags_reg_r[FLAG_C]);

	// Next state: bus access first, so an instruction in the same cycle wins
	always_comb
	begin
		st_nxt = st_r;
		wreg_nxt = wreg_r;
		io_nxt = io_r;
		stk_nxt = stk_r;
		sp_nxt = sp_r;
		status_flags_reg_nxt = status_flags_reg_r;
		hold_nxt = hold_r;
		done_nxt = 1'b0;
		rdata_nxt = 8'h00;
		if (bus_wr)
		begin
			case (area_of(bus_addr))
				AREA_WREG: wreg_nxt[bus_addr[4:0]] = bus_wdata;
				AREA_IO: io_nxt[bus_addr[4:0]] = bus_wdata;
				AREA_FLAGS: status_flags_reg_nxt = bus_wdata;
				AREA_SP: sp_nxt = bus_wdata[3:0];
				default: ;
			endcase
		end
		// Unmapped reads return zero
		if (bus_rd)
		begin
			case (area_of(bus_addr))
				AREA_WREG: rdata_nxt = wreg_r[bus_addr[4:0]];
				AREA_IO: rdata_nxt = io_r[bus_addr[4:0]];
				AREA_FLAGS: rdata_nxt = status_flags_reg_r;
				AREA_SP: rdata_nxt = {4'h0, sp_r};
				default: rdata_nxt = 8'h00;
			endcase
		end
		case (st_r)
			ST_IDLE:
			begin
				if (fire)
				begin
					case (cmd.op)
						OP_PUSH:
						begin
							stk_nxt[sp_r] = src_val;
							st_nxt = ST_PUSH2;
						end
						OP_POP:
						begin
							sp_nxt = sp_r + 4'h1;
							hold_nxt = cmd.reg_sel;
							st_nxt = ST_POP2;
						end
						OP_IO_SET:
						begin
							io_nxt[cmd.io_sel][cmd.bit_sel] = 1'b1;
							done_nxt = 1'b1;
						end
						OP_IO_CLR:
						begin
							io_nxt[cmd.io_sel][cmd.bit_sel] = 1'b0;
							done_nxt = 1'b1;
						end
						OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR:
						begin
							wreg_nxt[cmd.reg_sel] = sh[7:0];
							status_flags_reg_nxt[FLAG_C] = sh[8];
							status_flags_reg_nxt[FLAG_Z] = (sh[7:0] == 8'h00);
							status_flags_reg_nxt[FLAG_N] = sh[7];
							status_flags_reg_nxt[FLAG_V] = sh[7] ^ sh[8]; // N xor C after shift
							done_nxt = 1'b1;
						end
						OP_SWAP:
						begin
							wreg_nxt[cmd.reg_sel] = {src_val[3:0], src_val[7:4]};
							done_nxt = 1'b1;
						end
						OP_FSET:
						begin
							status_flags_reg_nxt[cmd.bit_sel] = 1'b1;
							done_nxt = 1'b1;
						end
						OP_FCLR:
						begin
							status_flags_reg_nxt[cmd.bit_sel] = 1'b0;
							done_nxt = 1'b1;
						end
						default: done_nxt = 1'b1;
					endcase
				end
			end
			// Stack grows down: pointer moves after the store
			ST_PUSH2:
			begin
				sp_nxt = sp_r - 4'h1;
				done_nxt = 1'b1;
				st_nxt = ST_IDLE;
			end
			ST_POP2:
			begin
				wreg_nxt[hold_r] = stk_r[sp_r];
				done_nxt = 1'b1;
				st_nxt = ST_IDLE;
			end
			default: st_nxt = ST_IDLE;
		endcase
		ready_nxt = (st_nxt == ST_IDLE);
	end

	// Registers only; arrays come up cleared so reads are defined
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_r <= ST_IDLE;
			for (int i = 0; i < 32; i++)
			begin
				wreg_r[i] <= BYTE_RST;
				io_r[i] <= BYTE_RST;
			end
			for (int i = 0; i < 16; i++)
			begin
				stk_r[i] <= BYTE_RST;
			end
			sp_r <= SP_RST;
			status_flags_reg_r <= FLAGS_RST;
			hold_r <= 5'h00;
			ready_r <= 1'b1;
			done_r <= 1'b0;
			rdata_r <= BYTE_RST;
		end
		else
		begin
			st_r <= st_nxt;
			wreg_r <= wreg_nxt;
			io_r <= io_nxt;
			stk_r <= stk_nxt;
			sp_r <= sp_nxt;
			status_flags_reg_r <= status_flags_reg_nxt;
			hold_r <= hold_nxt;
			ready_r <= ready_nxt;
			done_r <= done_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign cmd_ready = ready_r;
	assign done = done_r;
	assign bus_rdata = rdata_r;

	// ********************************************************
	// Checks
	// ********************************************************
	logic [7:0] top_byte;
	assign top_byte = stk_r[sp_r];

	AST_PUSH_TWO: assert property (@(posedge clk) disable iff (!rstn)
		fire && cmd.op == OP_PUSH |=> !done_r && !ready_r ##1 done_r && ready_r
			&& stk_r[sp_r + 4'h1] == $past(src_val, 2))
		else $error("push did not store and finish in two cycles");

	AST_PUSH_FLAGS: assert property (@(posedge clk) disable iff (!rstn)
		fire && cmd.op == OP_PUSH && !bus_wr |=> status_flags_reg_r == $past(status_flags_reg_r))
		else $error("push changed flags");

	AST_POP_LOAD: assert property (@(posedge clk) disable iff (!rstn)
		st_r == ST_POP2 |=> wreg_r[$past(hold_r)] == $past(top_byte) && done_r)
		else $error("pop loaded wrong byte");

	AST_IO_SET: assert property (@(posedge clk) disable iff (!rstn)
		fire && cmd.op == OP_IO_SET |=> io_r[$past(cmd.io_sel)]
			== ($past(io_r[cmd.io_sel]) | (8'h01 << $past(cmd.bit_sel))))
		else $error("io bit set wrong");

	AST_IO_CLR: assert property (@(posedge clk) disable iff (!rstn)
		fire && cmd.op == OP_IO_CLR && !bus_wr |=> io_r[$past(cmd.io_sel)]
			== ($past(io_r[cmd.io_sel]) & ~(8'h01 << $past(cmd.bit_sel))))
		else $error("io bit clear wrong");

	AST_LSL: assert property (@(posedge clk) disable iff (!rstn)
		fire && cmd.op == OP_LSL |=> wreg_r[$past(cmd.reg_sel)] == {$past(src_val[6:0]), 1'b0}
			&& status_flags_reg_r[FLAG_C] == $past(src_val[7]))
		else $error("shift left result wrong");

	AST_LSR: assert property (@(posedge clk) disable iff (!rstn)
		fire && cmd.op == OP_LSR |=> wreg_r[$past(cmd.reg_sel)] == {1'b0, $past(src_val[7:1])}
			&& !status_flags_reg_r[FLAG_N])
		else $error("shift right result wrong");

	AST_ROL: assert property (@(posedge clk) disable iff (!rstn)
		fire && cmd.op == OP_ROL |=> wreg_r[$past(cmd.reg_sel)][0]
			== $past(status_flags_reg_r[FLAG_C]) && status_flags_reg_r[FLAG_C] == $past(src_val[7]))
		else $error("rotate left wrong");

	AST_ROR: assert property (@(posedge clk) disable iff (!rstn)
		fire && cmd.op == OP_ROR |=> wreg_r[$past(cmd.reg_sel)][7]
			== $past(status_flags_reg_r[FLAG_C]) && status_flags_reg_r[FLAG_C] == $past(src_val[0]))
		else $error("rotate right wrong");

	AST_ASR: assert property (@(posedge clk) disable iff (!rstn)
		fire && cmd.op == OP_ASR |=> wreg_r[$past(cmd.reg_sel)]
			== {$past(src_val[7]), $past(src_val[7:1])})
		else $error("arithmetic shift wrong");

	AST_SHIFT_CARRY: assert property (@(posedge clk) disable iff (!rstn)
		fire && (cmd.op == OP_LSR || cmd.op == OP_ASR)
			|=> status_flags_reg_r[FLAG_C] == $past(src_val[0]))
		else $error("right shift carry wrong");

	AST_SWAP: assert property (@(posedge clk) disable iff (!rstn)
		fire && cmd.op == OP_SWAP && !bus_wr |=> wreg_r[$past(cmd.reg_sel)]
			== {$past(src_val[3:0]), $past(src_val[7:4])} && $stable(status_flags_reg_r))
		else $error("swap wrong");

	AST_FSET: assert property (@(posedge clk) disable iff (!rstn)
		fire && cmd.op == OP_FSET |=> done_r && status_flags_reg_r
			== ($past(status_flags_reg_r) | (8'h01 << $past(cmd.bit_sel))))
		else $error("flag set wrong");

	AST_FCLR: assert property (@(posedge clk) disable iff (!rstn)
		fire && cmd.op == OP_FCLR |=> status_flags_reg_r
			== ($past(status_flags_reg_r) & ~(8'h01 << $past(cmd.bit_sel))))
		else $error("flag clear wrong");

endmodule
